// ===== hdl/wsq_pkg.sv
/*
 Constants and carrier types of the wakeup source qualifier.
 Assumes one 200 MHz clock and a plain register port on the top module.
*/
package wsq_pkg;
   // Register offsets
   localparam logic [3:0] WSQ_OFS_PERIPH   = 4'h0;
   localparam logic [3:0] WSQ_OFS_FALL     = 4'h1;
   localparam logic [3:0] WSQ_OFS_RISE     = 4'h2;
   localparam logic [3:0] WSQ_OFS_COMMIT   = 4'h3;
   localparam logic [3:0] WSQ_OFS_PDOWN    = 4'h4;
   localparam logic [3:0] WSQ_OFS_DURATION = 4'h5;
   localparam logic [3:0] WSQ_OFS_STATUS   = 4'h6;
   localparam logic [3:0] WSQ_OFS_IFCTRL   = 4'h7;
   localparam logic [3:0] WSQ_OFS_OUTPINS  = 4'h8;
   // Peripheral field positions
   localparam int WSQ_B_TIMER = 0;
   localparam int WSQ_B_RADIO = 1;
   localparam int WSQ_B_WAKE  = 2;
   localparam int WSQ_B_SER1  = 3;
   localparam int WSQ_B_SER2  = 4;
   localparam int WSQ_B_SSI   = 5;
   localparam logic [7:0] WSQ_PERIPH_MASK = 8'h3F;
   // Interface control positions
   localparam int WSQ_B_SER1_ON = 0;
   localparam int WSQ_B_SER1_FC = 1;
   localparam int WSQ_B_SER2_ON = 2;
   localparam int WSQ_B_SER2_FC = 3;
   localparam int WSQ_B_SSI_ON  = 4;
   localparam int WSQ_B_SHORT   = 8;
   // Mode codes
   localparam logic [2:0] WSQ_MODE_SLEEP   = 3'h0;
   localparam logic [2:0] WSQ_MODE_STOP    = 3'h2;
   localparam logic [2:0] WSQ_MODE_STANDBY = 3'h4;
   // Result codes
   localparam logic [7:0] WSQ_RC_OK       = 8'h00;
   localparam logic [7:0] WSQ_RC_BADMODE  = 8'h03;
   localparam logic [7:0] WSQ_RC_NOTGPIO  = 8'h08;
   localparam logic [7:0] WSQ_RC_OUTPUT   = 8'h09;
   localparam logic [7:0] WSQ_RC_CONFLICT = 8'h0C;
   // GPIO bit indices, wider package variant
   localparam int WSQ_P_SHARED_SSI = 2;
   localparam int WSQ_P_SER2_DATA  = 6;
   localparam int WSQ_P_SER2_FLOW  = 7;
   localparam int WSQ_P_WAKE       = 8;
   localparam int WSQ_P_SER1_DATA  = 14;
   localparam int WSQ_P_SER1_FLOW  = 20;
   // Timing: one second of the sleep timer
   localparam int WSQ_SEC_NS     = 1000000000;
   localparam int WSQ_CLK_NS     = 5;
   localparam int WSQ_SEC_CYCLES = WSQ_SEC_NS / WSQ_CLK_NS;
   localparam int WSQ_GPIO_W     = 32;
   // Register port request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  addr;
      logic [31:0] wdata;
   } wsq_req_type;
   // Qualified configuration
   typedef struct packed {
      logic [7:0]  periph;
      logic [31:0] fall;
      logic [31:0] rise;
   } wsq_cfg_type;
endpackage

// ===== hdl/wsq_check.sv
/*
 Combinational validity check of a candidate wakeup configuration.
 Assumes the caller samples the result on its own commit strobe.
*/
module wsq_check
   import wsq_pkg::*;
(
   // Candidate
   input  wire wsq_pkg::wsq_cfg_type cand,
   input  wire logic [7:0]           ifctrl,
   input  wire logic [31:0]          out_pins,
   input  wire logic [31:0]          gpio_valid,
   input  wire logic                 variant_b,
   // Result
   output logic [7:0]                code,
   output logic [7:0]                pin
);
   import wsq_pkg::*;
   logic [31:0] sel;
   logic [31:0] bad;
   logic [31:0] used_out;
   logic [31:0] conflict;

   // Partner pin of an exclusive pair
   function automatic logic [31:0] pair_hits(input logic [31:0] s, input logic vb);
      logic [31:0] h;
      h = 32'h0000_0000;
      if (!vb) begin
         if (s[1] && s[23]) h[23] = 1'b1;
         if (s[2] && s[24]) h[24] = 1'b1;
         if (s[5] && s[19]) h[19] = 1'b1;
         if (s[9] && s[20]) h[20] = 1'b1;
      end else begin
         if (s[1] && s[25]) h[25] = 1'b1;
         if (s[2] && s[26]) h[26] = 1'b1;
         if (s[5] && s[21]) h[21] = 1'b1;
         if (s[9] && s[22]) h[22] = 1'b1;
         if (s[17] && s[24]) h[24] = 1'b1;
         if (s[18] && s[23]) h[23] = 1'b1;
      end
      return h;
   endfunction

   // Lowest set bit index
   function automatic logic [7:0] first_bit(input logic [31:0] v);
      logic [7:0] n;
      n = 8'h00;
      for (int i = 31; i >= 0; i--) begin
         if (v[i]) n = 8'(i);
      end
      return n;
   endfunction

   // Classify the candidate
   always_comb begin
      sel      = cand.fall | cand.rise;
      bad      = sel & ~gpio_valid;
      bad[WSQ_P_WAKE] = sel[WSQ_P_WAKE];
      used_out = sel & out_pins;
      conflict = pair_hits(sel, variant_b);
      if (ifctrl[WSQ_B_SSI_ON]) conflict[WSQ_P_SHARED_SSI] = sel[WSQ_P_SHARED_SSI];
      if (ifctrl[WSQ_B_SER2_ON]) begin
         conflict[WSQ_P_SER2_DATA] = sel[WSQ_P_SER2_DATA];
         if (ifctrl[WSQ_B_SER2_FC]) conflict[WSQ_P_SER2_FLOW] = sel[WSQ_P_SER2_FLOW];
      end
      if (ifctrl[WSQ_B_SER1_ON]) begin
         conflict[WSQ_P_SER1_DATA] = sel[WSQ_P_SER1_DATA];
         if (ifctrl[WSQ_B_SER1_FC]) conflict[WSQ_P_SER1_FLOW] = sel[WSQ_P_SER1_FLOW];
      end
      // Priority: not a GPIO, then output, then conflict
      if (bad != 32'h0000_0000) begin
         code = WSQ_RC_NOTGPIO;
         pin  = first_bit(bad);
      end else if (used_out != 32'h0000_0000) begin
         code = WSQ_RC_OUTPUT;
         pin  = first_bit(used_out);
      end else if (conflict != 32'h0000_0000) begin
         code = WSQ_RC_CONFLICT;
         pin  = first_bit(conflict);
      end else begin
         code = WSQ_RC_OK;
         pin  = 8'h00;
      end
   end
endmodule

// ===== hdl/wsq_timer.sv
/*
 Sleep timer: counts whole seconds after a start pulse.
 Assumes an active-low reset from the top module, asserted asynchronously and released synchronously.
*/
module wsq_timer
   import wsq_pkg::*;
#(
   parameter int SEC_CYCLES = WSQ_SEC_CYCLES
)(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Control
   input  wire logic        start,
   input  wire logic        stop,
   input  wire logic [31:0] seconds,
   // Status
   output logic             expired
);
   import wsq_pkg::*;
   logic [31:0] tick_r;
   logic [31:0] sec_r;
   logic        run_r;

   // Second prescaler and second countdown
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_r  <= 32'h0000_0000;
         sec_r   <= 32'h0000_0000;
         run_r   <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (start) begin
            tick_r <= 32'h0000_0000;
            sec_r  <= seconds;
            run_r  <= 1'b1;
         end else if (stop) begin
            run_r <= 1'b0;
         end else if (run_r) begin
            if (sec_r == 32'h0000_0000) begin
               expired <= 1'b1;
               run_r   <= 1'b0;
            end else if (tick_r == 32'(SEC_CYCLES - 1)) begin
               tick_r <= 32'h0000_0000;
               sec_r  <= sec_r - 32'h0000_0001;
            end else begin
               tick_r <= tick_r + 32'h0000_0001;
            end
         end
      end
   end
endmodule

// ===== hdl/wsq_top.sv
/*
 Wakeup source qualifier: holds the wakeup configuration, enters a
 low-power mode on request and raises one wake request when a source
 that is enabled and permitted in that mode fires.
 Assumes source event inputs are single-cycle pulses or levels
 synchronous to clk, and a register port driven by a local master.
*/
module wsq_top
   import wsq_pkg::*;
#(
   parameter int          SEC_CYCLES = WSQ_SEC_CYCLES,
   parameter logic [31:0] GPIO_VALID = 32'h07FB_F2FE
)(
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 nrst,
   // Register port
   input  wire wsq_pkg::wsq_req_type req,
   output logic [31:0]               rdata,
   // Package variant strap
   input  wire logic                 variant_b,
   // Wake source events
   input  wire logic                 radio_rx,
   input  wire logic                 ser1_rx,
   input  wire logic                 ser2_rx,
   input  wire logic                 ssi_rx,
   input  wire logic                 wake_pin,
   input  wire logic [31:0]          gpio_in,
   // Wake sequencing
   input  wire logic                 wake_ack,
   output logic                      wake_req,
   output logic                      low_power,
   output logic [2:0]                mode_out,
   output logic                      radio_rx_on
);
   import wsq_pkg::*;

   typedef enum logic [1:0] {ST_RUN, ST_DOWN, ST_WAKE} wsq_state_type;

   logic          rst_s1_r;
   logic          rst_n;
   wsq_cfg_type   cfg_r;
   wsq_cfg_type   cand_r;
   logic [7:0]    ifctrl_r;
   logic [31:0]   out_pins_r;
   logic [31:0]   duration_r;
   logic [2:0]    mode_r;
   logic [7:0]    code_r;
   logic [7:0]    pin_r;
   logic [7:0]    chk_code;
   logic [7:0]    chk_pin;
   wsq_state_type state_r;
   logic          timer_start;
   logic          timer_exp;
   logic [31:0]   gpio_d_r;
   logic          wake_d_r;
   logic [31:0]   gpio_hit;
   logic          wake_hit;
   logic          any_hit;
   logic          pdown_ok;
   logic [7:0]    wake_cause_r;
   logic          short_r;
   logic [2:0]    mode_nxt;

   // Reset release through two flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end

   // Mode code check
   function automatic logic mode_valid(input logic [2:0] m);
      return (m == WSQ_MODE_SLEEP) || (m == WSQ_MODE_STOP) || (m == WSQ_MODE_STANDBY);
   endfunction

   // Configuration validity check
   wsq_check u_check (
      .cand       (cand_r),
      .ifctrl     (ifctrl_r),
      .out_pins   (out_pins_r),
      .gpio_valid (short_r ? {8'h00, GPIO_VALID[23:0]} : GPIO_VALID),
      .variant_b  (variant_b),
      .code       (chk_code),
      .pin        (chk_pin)
   );

   assign pdown_ok = req.wr && (req.addr == WSQ_OFS_PDOWN) && mode_valid(req.wdata[2:0]) && (state_r == ST_RUN);
   assign timer_start = pdown_ok && cfg_r.periph[WSQ_B_TIMER];
   // Mode seen by the outputs from the power-down edge on
   assign mode_nxt = pdown_ok ? req.wdata[2:0] : mode_r;

   // Sleep timer
   wsq_timer #(
      .SEC_CYCLES (SEC_CYCLES)
   ) u_timer (
      .clk     (clk),
      .rst_n   (rst_n),
      .start   (timer_start),
      .stop    (state_r != ST_DOWN),
      .seconds (duration_r),
      .expired (timer_exp)
   );

   // Candidate and interface configuration writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cand_r     <= '0;
         ifctrl_r   <= 8'h00;
         out_pins_r <= 32'h0000_0000;
         duration_r <= 32'h0000_0000;
      end else if (req.wr) begin
         if (req.addr == WSQ_OFS_PERIPH) begin
            cand_r.periph <= req.wdata[7:0] & WSQ_PERIPH_MASK;
         end else if (req.addr == WSQ_OFS_FALL) begin
            cand_r.fall <= req.wdata;
         end else if (req.addr == WSQ_OFS_RISE) begin
            cand_r.rise <= req.wdata;
         end else if (req.addr == WSQ_OFS_DURATION) begin
            duration_r <= req.wdata;
         end else if (req.addr == WSQ_OFS_IFCTRL) begin
            ifctrl_r <= req.wdata[7:0];
         end else if (req.addr == WSQ_OFS_OUTPINS) begin
            out_pins_r <= req.wdata;
         end
      end
   end

   // Short-mask flag lives in ifctrl bit 8 region, kept separate
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         short_r <= 1'b0;
      end else if (req.wr && req.addr == WSQ_OFS_IFCTRL) begin
         short_r <= req.wdata[WSQ_B_SHORT];
      end
   end

   // Commit: accept candidate only when it checks clean
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r  <= '0;
         code_r <= WSQ_RC_OK;
         pin_r  <= 8'h00;
      end else if (req.wr && req.addr == WSQ_OFS_COMMIT) begin
         code_r <= chk_code;
         pin_r  <= chk_pin;
         if (chk_code == WSQ_RC_OK) begin
            cfg_r <= cand_r;
            if (short_r) begin
               cfg_r.fall[31:24] <= 8'h00;
               cfg_r.rise[31:24] <= 8'h00;
            end
         end
      end else if (req.wr && req.addr == WSQ_OFS_PDOWN && !mode_valid(req.wdata[2:0])) begin
         code_r <= WSQ_RC_BADMODE;
      end
   end

   // Edge detection history
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gpio_d_r <= 32'h0000_0000;
         wake_d_r <= 1'b0;
      end else begin
         gpio_d_r <= gpio_in;
         wake_d_r <= wake_pin;
      end
   end

   // Source qualification per mode
   always_comb begin
      gpio_hit = (cfg_r.rise & gpio_in & ~gpio_d_r) | (cfg_r.fall & ~gpio_in & gpio_d_r);
      gpio_hit[WSQ_P_WAKE] = 1'b0;
      wake_hit = cfg_r.periph[WSQ_B_WAKE] && wake_pin && !wake_d_r;
      any_hit  = 1'b0;
      if (mode_r == WSQ_MODE_SLEEP) begin
         // Any enabled source except the wake pin, first one wins
         any_hit = (gpio_hit != 32'h0000_0000) || timer_exp
                   || (cfg_r.periph[WSQ_B_RADIO] && radio_rx)
                   || (cfg_r.periph[WSQ_B_SER1] && ser1_rx)
                   || (cfg_r.periph[WSQ_B_SER2] && ser2_rx)
                   || (cfg_r.periph[WSQ_B_SSI] && ssi_rx);
      end else if (mode_r == WSQ_MODE_STOP) begin
         // Serial activity masked silently
         any_hit = (gpio_hit != 32'h0000_0000) || timer_exp
                   || (cfg_r.periph[WSQ_B_RADIO] && radio_rx);
      end else begin
         any_hit = timer_exp || wake_hit;
      end
   end

   // Power state sequencing
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_RUN;
         mode_r  <= WSQ_MODE_SLEEP;
      end else begin
         case (state_r)
            ST_RUN: begin
               if (pdown_ok) begin
                  state_r <= ST_DOWN;
                  mode_r  <= req.wdata[2:0];
               end
            end
            ST_DOWN: begin
               if (any_hit) state_r <= ST_WAKE;
            end
            ST_WAKE: begin
               if (wake_ack) state_r <= ST_RUN;
            end
            default: state_r <= ST_RUN;
         endcase
      end
   end

   // Wake cause capture
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_cause_r <= 8'h00;
      end else if (state_r == ST_DOWN && any_hit) begin
         wake_cause_r <= {2'b00, ssi_rx, ser2_rx, ser1_rx, wake_hit, radio_rx, timer_exp};
      end
   end

   // Registered outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_req    <= 1'b0;
         low_power   <= 1'b0;
         mode_out    <= WSQ_MODE_SLEEP;
         radio_rx_on <= 1'b0;
      end else begin
         wake_req    <= (state_r == ST_DOWN && any_hit) || (state_r == ST_WAKE && !wake_ack);
         low_power   <= (state_r == ST_DOWN) || (state_r == ST_WAKE && !wake_ack)
                        || (state_r == ST_RUN && pdown_ok);
         mode_out    <= mode_nxt;
         radio_rx_on <= cfg_r.periph[WSQ_B_RADIO] && mode_nxt != WSQ_MODE_STANDBY;
      end
   end

   // Read data, valid in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h0000_0000;
      end else if (req.rd) begin
         if (req.addr == WSQ_OFS_PERIPH) begin
            rdata <= {24'h000000, cfg_r.periph};
         end else if (req.addr == WSQ_OFS_FALL) begin
            rdata <= cfg_r.fall;
         end else if (req.addr == WSQ_OFS_RISE) begin
            rdata <= cfg_r.rise;
         end else if (req.addr == WSQ_OFS_PDOWN) begin
            rdata <= {27'h0000000, mode_r, 2'(state_r)};
         end else if (req.addr == WSQ_OFS_DURATION) begin
            rdata <= duration_r;
         end else if (req.addr == WSQ_OFS_STATUS) begin
            rdata <= {8'h00, wake_cause_r, pin_r, code_r};
         end else if (req.addr == WSQ_OFS_IFCTRL) begin
            rdata <= {23'h000000, short_r, ifctrl_r};
         end else if (req.addr == WSQ_OFS_OUTPINS) begin
            rdata <= out_pins_r;
         end else begin
            rdata <= 32'h0000_0000;
         end
      end else begin
         rdata <= 32'h0000_0000;
      end
   end
endmodule

// ===== bench/wsq_host.sv
/*
 Host model: masters the register port of the qualifier and raises
 serial-interface wake bursts with the select pin pulled low first.
 Assumes the bench owns the clock and reset and calls these tasks.
*/
module wsq_host
   import wsq_pkg::*;
#(
   parameter int LEAD_CYCLES = 10
)(
   // Clock
   input  wire logic                 clk,
   // Register port
   output wsq_pkg::wsq_req_type      req,
   input  wire logic [31:0]          rdata,
   // Serial-interface wake
   output logic                      ssi_rx,
   output logic                      ssi_sel_n
);
   timeunit 1ns;
   timeprecision 1ps;
   import wsq_pkg::*;

   // Idle bus and released select at time zero
   initial begin
      req = '0;
      ssi_rx = 1'b0;
      ssi_sel_n = 1'b1;
   end

   // One write cycle, strobe for a single clock
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req <= '0;
   endtask

   // One read cycle, data taken in the following cycle only
   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk);
      req <= '0;
      @(negedge clk);
      d = rdata;
   endtask

   // Select pin low for the lead time, then the transfer
   task automatic ssi_wake();
      @(posedge clk);
      ssi_sel_n <= 1'b0;
      repeat (LEAD_CYCLES) @(posedge clk);
      ssi_rx <= 1'b1;
      @(posedge clk);
      ssi_rx <= 1'b0;
      ssi_sel_n <= 1'b1;
   endtask
endmodule

// ===== bench/wsq_top_asserts.sv
/*
 Port-level checker of the wakeup source qualifier.
 Assumes it is bound into wsq_top and sees only its ports.
*/
module wsq_top_asserts
   import wsq_pkg::*;
#(
   parameter int          SEC_CYCLES = WSQ_SEC_CYCLES,
   parameter logic [31:0] GPIO_VALID = 32'h07FB_F2FE
)(
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 nrst,
   // Watched ports
   input  wire wsq_pkg::wsq_req_type req,
   input  wire logic [31:0]          rdata,
   input  wire logic                 wake_ack,
   input  wire logic                 wake_req,
   input  wire logic                 low_power,
   input  wire logic [2:0]           mode_out,
   input  wire logic                 radio_rx_on
);
   import wsq_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // Power-down write decode
   wire logic pd_wr = req.wr && req.addr == WSQ_OFS_PDOWN;
   wire logic mode_ok = req.wdata[2:0] == WSQ_MODE_SLEEP || req.wdata[2:0] == WSQ_MODE_STOP
                        || req.wdata[2:0] == WSQ_MODE_STANDBY;

   // Wake request handshake
   ack_release_a: assert property (wake_ack |=> !wake_req && !low_power)
      else $error("wake request kept after acknowledge");
   req_hold_a: assert property (wake_req && !wake_ack |=> wake_req)
      else $error("wake request dropped before acknowledge");
   req_in_lp_a: assert property (wake_req |-> low_power)
      else $error("wake request outside low power");
   lp_hold_a: assert property (low_power && !wake_ack |=> low_power)
      else $error("low power left without acknowledge");
   // Mode entry and selector codes
   pd_enter_a: assert property (pd_wr && mode_ok && !low_power |=> low_power && mode_out == $past(req.wdata[2:0]))
      else $error("valid power-down not entered");
   bad_mode_a: assert property (pd_wr && !mode_ok && !low_power |=> !low_power)
      else $error("invalid mode entered low power");
   mode_keep_a: assert property (!pd_wr |=> $stable(mode_out))
      else $error("mode changed without power-down write");
   standby_radio_a: assert property (low_power && $past(low_power) && mode_out == WSQ_MODE_STANDBY |-> !radio_rx_on)
      else $error("radio left on in standby");
   // Read port
   rdata_idle_a: assert property (!req.rd |=> rdata == 32'h0)
      else $error("read data outside read answer");
   unmapped_rd_a: assert property (req.rd && req.addr == 4'hF |=> rdata == 32'h0)
      else $error("unmapped read not zero");

   // Main scenarios
   cov_wake: cover property (wake_req && wake_ack);
   cov_stop: cover property (low_power && mode_out == WSQ_MODE_STOP);
   cov_standby: cover property (low_power && mode_out == WSQ_MODE_STANDBY);
endmodule

bind wsq_top wsq_top_asserts #(.SEC_CYCLES(SEC_CYCLES), .GPIO_VALID(GPIO_VALID)) chk (
   .clk(clk), .nrst(nrst), .req(req), .rdata(rdata), .wake_ack(wake_ack), .wake_req(wake_req),
   .low_power(low_power), .mode_out(mode_out), .radio_rx_on(radio_rx_on));

// ===== bench/wsq_top_test.sv
/*
 Self-checking bench of the wakeup source qualifier.
 Assumes the host model drives the register port and the serial-interface wake; the bench drives the other events.
*/
module wsq_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   import wsq_pkg::*;
   localparam int SECS = 10;

   logic                 clk = 1'b0;
   logic                 nrst = 1'b0;
   wsq_pkg::wsq_req_type req;
   logic [31:0]          rdata;
   logic                 variant_b = 1'b1;
   logic [5:0]           pulse = 6'h0;
   logic                 ssi_rx;
   logic                 ssi_sel_n;
   logic [31:0]          gpio_in;
   logic                 wake_ack = 1'b0;
   logic                 wake_req;
   logic                 low_power;
   logic [2:0]           mode_out;
   logic                 radio_rx_on;
   logic [31:0]          st;
   logic                 seen;
   int                   miscompares = 0;
   int                   tests_run = 0;
   logic [2:0]           modes [3] = '{WSQ_MODE_SLEEP, WSQ_MODE_STOP, WSQ_MODE_STANDBY};
   logic [5:0]           allow [3] = '{6'h2F, 6'h21, 6'h10};

   // Clock, and GPIO idle high with pin 3 and the select pin switching
   always #2.5 clk = ~clk;
   assign gpio_in = {27'h7FF_FFFF, ssi_sel_n, ~pulse[5], 3'h7};

   wsq_host host (.clk(clk), .req(req), .rdata(rdata), .ssi_rx(ssi_rx), .ssi_sel_n(ssi_sel_n));

   wsq_top #(.SEC_CYCLES(SECS)) uut (
      .clk(clk), .nrst(nrst), .req(req), .rdata(rdata), .variant_b(variant_b),
      .radio_rx(pulse[0]), .ser1_rx(pulse[1]), .ser2_rx(pulse[2]), .ssi_rx(ssi_rx),
      .wake_pin(pulse[4]), .gpio_in(gpio_in), .wake_ack(wake_ack), .wake_req(wake_req),
      .low_power(low_power), .mode_out(mode_out), .radio_rx_on(radio_rx_on));

   // Compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask

   // Verdict and end of run
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Candidate configuration, commit, status compare
   task automatic cfg(input logic [31:0] f, r, ic, op, input logic [7:0] code, pin, input logic any);
      host.reg_write(WSQ_OFS_FALL, f);
      host.reg_write(WSQ_OFS_RISE, r);
      host.reg_write(WSQ_OFS_IFCTRL, ic);
      host.reg_write(WSQ_OFS_OUTPINS, op);
      host.reg_write(WSQ_OFS_COMMIT, 32'h0);
      host.reg_read(WSQ_OFS_STATUS, st);
      if (any)
         check({31'h0, st[7:0] != 8'h00}, 32'h1);
      else
         check({16'h0, st[15:0]}, {16'h0, pin, code});
   endtask

   // One-cycle source event, serial interface through the host
   task automatic fire(input int s);
      if (s == 3) begin
         host.ssi_wake();
      end else begin
         @(posedge clk);
         pulse[s] <= 1'b1;
         @(posedge clk);
         pulse[s] <= 1'b0;
      end
   endtask

   // Sticky look for a wake request over n cycles
   task automatic watch(input int n);
      seen = 1'b0;
      repeat (n) begin
         @(negedge clk);
         if (wake_req === 1'b1)
            seen = 1'b1;
      end
   endtask

   // Acknowledge the wake and see low power left
   task automatic ack();
      @(posedge clk);
      wake_ack <= 1'b1;
      @(posedge clk);
      wake_ack <= 1'b0;
      @(negedge clk);
      check({31'h0, low_power}, 32'h0);
   endtask

   // Watchdog over the whole expected run
   initial begin
      #50000;
      miscompares++;
      wrap_up();
   end

   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      host.reg_read(WSQ_OFS_STATUS, st);
      check(st, 32'h0);
      host.reg_read(4'hF, st);
      check(st, 32'h0);
      $display("Reset values done");
      // Reserved peripheral bits dropped
      host.reg_write(WSQ_OFS_PERIPH, 32'hFF);
      cfg(32'h0, 32'h0, 32'h0, 32'h0, WSQ_RC_OK, 8'h00, 1'b0);
      host.reg_read(WSQ_OFS_PERIPH, st);
      check(st, 32'h3F);
      // Rejections and pin sharing
      cfg(32'h1, 32'h0, 32'h0, 32'h0, WSQ_RC_NOTGPIO, 8'd0, 1'b0);
      cfg(32'h100, 32'h0, 32'h0, 32'h0, WSQ_RC_NOTGPIO, 8'd8, 1'b0);
      cfg(32'h0, 32'h0200_0000, 32'h100, 32'h0, WSQ_RC_NOTGPIO, 8'd25, 1'b0);
      cfg(32'h2, 32'h0, 32'h0, 32'h2, WSQ_RC_OUTPUT, 8'd1, 1'b0);
      cfg(32'h20, 32'h0020_0000, 32'h0, 32'h0, WSQ_RC_CONFLICT, 8'd21, 1'b0);
      cfg(32'h4, 32'h0, 32'h10, 32'h0, 8'h0, 8'h0, 1'b1);
      cfg(32'h40, 32'h0, 32'h4, 32'h0, 8'h0, 8'h0, 1'b1);
      cfg(32'h80, 32'h0, 32'hC, 32'h0, 8'h0, 8'h0, 1'b1);
      cfg(32'h80, 32'h0, 32'h4, 32'h0, WSQ_RC_OK, 8'h00, 1'b0);
      cfg(32'h4000, 32'h0, 32'h1, 32'h0, 8'h0, 8'h0, 1'b1);
      cfg(32'h0010_0000, 32'h0, 32'h3, 32'h0, 8'h0, 8'h0, 1'b1);
      cfg(32'h0010_0000, 32'h0, 32'h1, 32'h0, WSQ_RC_OK, 8'h00, 1'b0);
      $display("Configuration checks done");
      // Invalid mode refused with code 3
      host.reg_write(WSQ_OFS_PDOWN, 32'h1);
      host.reg_read(WSQ_OFS_STATUS, st);
      check({24'h0, st[7:0]}, {24'h0, WSQ_RC_BADMODE});
      // All sources enabled, GPIO 3 falling, long timer
      cfg(32'h8, 32'h0, 32'h0, 32'h0, WSQ_RC_OK, 8'h00, 1'b0);
      host.reg_write(WSQ_OFS_DURATION, 32'd200);
      for (int m = 0; m < 3; m++) begin
         for (int s = 0; s < 6; s++) begin
            host.reg_write(WSQ_OFS_PDOWN, {29'h0, modes[m]});
            @(negedge clk);
            check({29'h0, mode_out}, {29'h0, modes[m]});
            check({31'h0, radio_rx_on}, {31'h0, m != 2});
            fire(s);
            watch(8);
            check({31'h0, seen}, {31'h0, allow[m][s]});
            if (!seen) begin
               fire(m == 2 ? 4 : 0);
               watch(4);
               check({31'h0, seen}, 32'h1);
            end
            ack();
         end
      end
      $display("Mode source matrix done");
      // Timer wake after the requested seconds, every mode
      host.reg_write(WSQ_OFS_DURATION, 32'd3);
      for (int m = 0; m < 3; m++) begin
         host.reg_write(WSQ_OFS_PDOWN, {29'h0, modes[m]});
         watch(25);
         check({31'h0, seen}, 32'h0);
         watch(15);
         check({31'h0, seen}, 32'h1);
         ack();
      end
      $display("Timer wake done");
      wrap_up();
   end
endmodule
